// ### pkg/touch_cfg.svh
`ifndef TOUCH_CFG_SVH
`define TOUCH_CFG_SVH

// ----------------------------------------
// command word layout
// ----------------------------------------
`define CMD_W 8
`define CMD_RESET 8'h00
`define BIT_START 7
`define CHAN_HI 6
`define CHAN_LO 4
`define BIT_RES 3
`define BIT_SER 2
`define BIT_REFPD 1
`define BIT_ADCPD 0

// ----------------------------------------
// channel codes
// ----------------------------------------
`define CH_DIODE_LOW 3'h0
`define CH_Y_AXIS 3'h1
`define CH_BATTERY 3'h2
`define CH_PRESS_ONE 3'h3
`define CH_PRESS_TWO 3'h4
`define CH_X_AXIS 3'h5
`define CH_AUX 3'h6
`define CH_DIODE_HIGH 3'h7

// ----------------------------------------
// serial clock edge numbers within a frame, counter width and result lengths
// ----------------------------------------
`define CNT_W 5
`define EDGE_REF_APPLY 5'h07
`define EDGE_ADC_APPLY 5'h08
`define EDGE_SW_LATCH 5'h05
`define EDGE_SER_LATCH 5'h06
`define EDGE_TRACK_START 5'h05
`define EDGE_TRACK_END 5'h08
`define EDGE_DOUT_START 5'h09
`define EDGE_CONV_END 5'h14
`define EDGE_REARM 5'h0f
`define RES_W 12
`define RES12_LEFT 4'hb
`define RES8_LEFT 4'h7

`endif

// ### pkg/touch_pkg.sv
`include "touch_cfg.svh"

package touch_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_OFF,
    PH_HUNT,
    PH_FRAME
  } phase_t;

  typedef enum logic [1:0] {
    REF_INTERNAL,
    REF_Y_PLATE,
    REF_YP_XN,
    REF_X_PLATE
  } ref_sel_t;

  typedef struct packed {
    phase_t phase;
    logic sck_d;
    logic [`CNT_W-1:0] rc;
    logic [`CNT_W-1:0] cv;
    logic [`CMD_W-1:0] shreg;
    logic [`CMD_W-1:0] cmd;
    logic [2:0] sw_chan;
    logic fr_mode;
    logic fr_diff;
    logic fr_na;
    logic [`RES_W-1:0] cap;
    logic [`RES_W-1:0] out_sh;
    logic [3:0] out_left;
    logic dout;
    logic dout_oe;
    logic alert_n;
    logic xp_sw;
    logic xn_sw;
    logic yp_sw;
    logic ym_sw;
    logic ref_on;
    logic adc_on;
    logic track;
    logic pen_en;
    logic diff_en;
    ref_sel_t ref_sel;
  } state_t;

endpackage : touch_pkg

// ### hw/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r <= '0;
      pin_sync_out <= '0;
    end
    else
    begin
      meta_r <= pin_in;
      pin_sync_out <= meta_r;
    end
  end

endmodule : pin_sync

// ### hw/touch_ctrl.sv
`timescale 1ns/1ps
`include "touch_cfg.svh"

// Notes on behaviour
// R1: command bits sampled on serial clock rise
// R2: word is start, channel, resolution, mode, powers
// R3: host sends start flag as one
// R4: resolution bit picks 12 or 8 bits
// R5: single-ended channel codes pick the inputs
// R6: each axis closes its own plate switches
// R7: three differential codes unusable, aux two single
// R8: differential reference is the driven plate
// R9: reference power applied at seventh rise
// R10: converter power applied at eighth rise
// R11: converter-on holds switches until fifth rise
// R12: deselected: only y minus switch closed
// R13: both bits zero: automatic converter power
// R14: both zero: pen detect except conversion
// R15: converter-on: powered, axis switches closed
// R16: reference-on: pen off fifth to twentieth fall
// R17: both on: alert forced high when deselected
// R18: decoding begins at first high bit
// R19: result msb first from ninth fall
// R20: full power-down clears command, plates open
// R21: tracking from fifth to eighth fall
// R22: unusable differential codes open all switches
module touch_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // pen sense and converter
  input wire logic plate_contact,
  input wire logic [`RES_W-1:0] conv_result,
  output logic touch_alert_n,
  output logic pen_detect_en,
  // plate drivers
  output logic x_plus_terminal,
  output logic x_minus_terminal,
  output logic y_plus_terminal,
  output logic y_minus_terminal,
  // analog control
  output logic ref_power_on,
  output logic adc_power_on,
  output logic tracking,
  output logic [2:0] channel_select,
  output logic differential_en,
  output touch_pkg::ref_sel_t ref_select,
  output logic res_8bit
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pins_s;
  logic cs_s, sck_s, din_s, touch_s;

  pin_sync #(.WIDTH(4)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in({~chip_select_n, serial_clock, serial_in, plate_contact}),
    .pin_sync_out(pins_s)
  );

  // select synced active high so a cleared synchroniser reads deselected
  assign {cs_s, sck_s, din_s, touch_s} = {~pins_s[3], pins_s[2:0]};

  // ----------------------------------------
  // state
  // ----------------------------------------
  touch_pkg::state_t st_r;
  touch_pkg::state_t st_nxt;
  logic rise, fall;

  assign rise = sck_s & ~st_r.sck_d;
  assign fall = ~sck_s & st_r.sck_d;

  function automatic logic is_axis(input logic [2:0] c);
    is_axis = (c == `CH_Y_AXIS) || (c == `CH_PRESS_ONE) ||
              (c == `CH_PRESS_TWO) || (c == `CH_X_AXIS);
  endfunction : is_axis

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic drive, busy, pd0, pd1;
    drive = 1'b0;
    busy = 1'b0;
    pd0 = 1'b0;
    pd1 = 1'b0;
    st_nxt = st_r;
    st_nxt.sck_d = sck_s;
    if (cs_s)
    begin
      st_nxt.rc = '0;
      st_nxt.cv = '0;
      st_nxt.track = 1'b0;
      st_nxt.out_left = '0;
      st_nxt.dout = 1'b0;
      st_nxt.fr_na = 1'b0;
      if (din_s)
      begin
        st_nxt.phase = touch_pkg::PH_OFF;
        st_nxt.cmd = `CMD_RESET; // R20
      end
      else
        st_nxt.phase = touch_pkg::PH_IDLE;
    end
    else
    begin
      if (st_r.phase == touch_pkg::PH_IDLE ||
          st_r.phase == touch_pkg::PH_OFF)
        st_nxt.phase = touch_pkg::PH_HUNT;
      if (rise) // R1
      begin
        st_nxt.shreg = {st_r.shreg[`CMD_W-2:0], din_s};
        if (st_r.rc == '0 || st_r.rc == `EDGE_REARM)
        begin
          // a low bit while hunting is not a command
          st_nxt.rc = din_s ? 5'h01 : 5'h00; // R18
          st_nxt.phase = din_s ? touch_pkg::PH_FRAME : touch_pkg::PH_HUNT;
        end
        else
          st_nxt.rc = st_r.rc + 5'h01;
        if (st_r.rc == `EDGE_SW_LATCH - 5'h01)
        begin
          // new channel takes over the switches only now
          st_nxt.sw_chan = st_r.shreg[2:0]; // R11
          st_nxt.fr_mode = din_s; // R4
        end
        if (st_r.rc == `EDGE_SER_LATCH - 5'h01)
        begin
          // aux two is always measured single-ended
          st_nxt.fr_diff = ~din_s && (st_r.sw_chan != `CH_AUX); // R7
          st_nxt.fr_na = ~din_s && (st_r.sw_chan == `CH_DIODE_LOW ||
                         st_r.sw_chan == `CH_BATTERY ||
                         st_r.sw_chan == `CH_DIODE_HIGH); // R22
        end
        if (st_r.rc == `EDGE_REF_APPLY - 5'h01)
          st_nxt.cmd[`BIT_REFPD] = din_s; // R9
        if (st_r.rc == `EDGE_ADC_APPLY - 5'h01)
          st_nxt.cmd = {st_r.shreg[`CMD_W-2:0], din_s}; // R2 R10
      end
      if (fall)
      begin
        if (st_r.rc == `EDGE_TRACK_START)
        begin
          st_nxt.track = 1'b1; // R21
          st_nxt.cv = `EDGE_TRACK_START;
        end
        else if (st_r.cv == `EDGE_CONV_END - 5'h01)
          st_nxt.cv = '0;
        else if (st_r.cv != '0)
          st_nxt.cv = st_r.cv + 5'h01;
        if (st_r.rc == `EDGE_TRACK_END)
        begin
          st_nxt.track = 1'b0; // R21
          // an unusable code gives a harmless all-zero result
          st_nxt.cap = st_r.fr_na ? '0 : conv_result; // R22
        end
        if (st_r.rc == `EDGE_DOUT_START)
        begin
          st_nxt.dout = st_r.cap[`RES_W-1]; // R19
          st_nxt.out_sh = {st_r.cap[`RES_W-2:0], 1'b0};
          st_nxt.out_left = st_r.fr_mode ? `RES8_LEFT : `RES12_LEFT; // R4
        end
        else if (st_r.out_left != '0)
        begin
          st_nxt.dout = st_r.out_sh[`RES_W-1]; // R19
          st_nxt.out_sh = {st_r.out_sh[`RES_W-2:0], 1'b0};
          st_nxt.out_left = st_r.out_left - 4'h1;
        end
        else
          st_nxt.dout = 1'b0;
      end
    end

    // power, switches and alert follow the updated state
    pd0 = st_nxt.cmd[`BIT_ADCPD];
    pd1 = st_nxt.cmd[`BIT_REFPD];
    busy = (st_nxt.cv != '0);
    drive = ~cs_s && ~st_nxt.fr_na &&
            ((pd0 && is_axis(st_nxt.sw_chan)) || st_nxt.track ||
             (st_nxt.fr_diff && busy)); // R15 R11
    st_nxt.xp_sw = 1'b0;
    st_nxt.xn_sw = 1'b0;
    st_nxt.yp_sw = 1'b0;
    st_nxt.ym_sw = 1'b0;
    if (drive)
    begin
      case (st_nxt.sw_chan) // R6
        `CH_Y_AXIS:
        begin
          st_nxt.yp_sw = 1'b1;
          st_nxt.ym_sw = 1'b1;
        end
        `CH_PRESS_ONE, `CH_PRESS_TWO:
        begin
          st_nxt.xn_sw = 1'b1;
          st_nxt.yp_sw = 1'b1;
        end
        `CH_X_AXIS:
        begin
          st_nxt.xp_sw = 1'b1;
          st_nxt.xn_sw = 1'b1;
        end
        default:
          st_nxt.ym_sw = 1'b0;
      endcase
    end
    else
      st_nxt.ym_sw = ~(cs_s && din_s) && ~st_nxt.fr_na; // R12 R20 R22

    st_nxt.ref_on = pd1; // R9 R16
    // converter runs for the conversion, or all frame in converter-on
    st_nxt.adc_on = (~cs_s && (pd0 || busy)) || (pd0 && pd1); // R13 R17

    if (cs_s && din_s)
    begin
      st_nxt.alert_n = 1'b1;
      st_nxt.pen_en = 1'b0;
    end
    else if (cs_s)
    begin
      st_nxt.pen_en = ~(pd0 && pd1); // R17
      st_nxt.alert_n = (pd0 && pd1) ? 1'b1 : ~touch_s; // R17
    end
    else if (busy)
    begin
      st_nxt.pen_en = 1'b0; // R14 R16
      st_nxt.alert_n = ~is_axis(st_nxt.sw_chan);
    end
    else if (~pd0)
    begin
      st_nxt.pen_en = 1'b1; // R14
      st_nxt.alert_n = ~touch_s;
    end
    else
    begin
      st_nxt.pen_en = 1'b0;
      st_nxt.alert_n = ~is_axis(st_nxt.cmd[`CHAN_HI:`CHAN_LO]);
    end

    st_nxt.dout_oe = ~cs_s;
    st_nxt.diff_en = st_nxt.fr_diff;
    case (st_nxt.sw_chan) // R8 R5
      `CH_Y_AXIS:
        st_nxt.ref_sel = st_nxt.fr_diff ? touch_pkg::REF_Y_PLATE
                                        : touch_pkg::REF_INTERNAL;
      `CH_PRESS_ONE, `CH_PRESS_TWO:
        st_nxt.ref_sel = st_nxt.fr_diff ? touch_pkg::REF_YP_XN
                                        : touch_pkg::REF_INTERNAL;
      `CH_X_AXIS:
        st_nxt.ref_sel = st_nxt.fr_diff ? touch_pkg::REF_X_PLATE
                                        : touch_pkg::REF_INTERNAL;
      default:
        st_nxt.ref_sel = touch_pkg::REF_INTERNAL;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.alert_n <= 1'b1;
      st_r.ym_sw <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign serial_out = st_r.dout;
  assign serial_out_oe = st_r.dout_oe;
  assign touch_alert_n = st_r.alert_n;
  assign pen_detect_en = st_r.pen_en;
  assign x_plus_terminal = st_r.xp_sw;
  assign x_minus_terminal = st_r.xn_sw;
  assign y_plus_terminal = st_r.yp_sw;
  assign y_minus_terminal = st_r.ym_sw;
  assign ref_power_on = st_r.ref_on;
  assign adc_power_on = st_r.adc_on;
  assign tracking = st_r.track;
  assign channel_select = st_r.sw_chan;
  assign differential_en = st_r.diff_en;
  assign ref_select = st_r.ref_sel;
  assign res_8bit = st_r.fr_mode;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rise_at(int k);
    rise && !cs_s && st_r.rc == k;
  endsequence

  sequence s_fall_at(int k);
    fall && !cs_s && st_r.rc == k;
  endsequence

  a_ref_apply: assert property (s_rise_at(6) |=> // R9
    ref_power_on == $past(din_s))
    else $error("reference power not applied at seventh rise");

  a_adc_apply: assert property (s_rise_at(7) |=> // R10
    st_r.cmd[`BIT_ADCPD] == $past(din_s) ##1 adc_power_on || cs_s)
    else $error("converter power bit not applied at eighth rise");

  a_hunt_start: assert property (rise && !cs_s && st_r.rc == '0 && // R18
    !din_s |=> st_r.rc == '0)
    else $error("low bit started a command");

  a_idle_switch: assert property (cs_s && !din_s ##1 cs_s && !din_s // R12
    |=> !x_plus_terminal && !x_minus_terminal && !y_plus_terminal
        && y_minus_terminal)
    else $error("switches wrong while deselected");

  a_full_down: assert property (cs_s && din_s |=> // R20
    st_r.cmd == `CMD_RESET && !y_minus_terminal && touch_alert_n)
    else $error("full power-down did not clear");

  a_track_win: assert property (s_fall_at(5) |=> tracking && // R21
    st_r.cv == `EDGE_TRACK_START ##1 (tracking || cs_s))
    else $error("tracking did not start at fifth fall");

  a_track_end: assert property (s_fall_at(8) |=> !tracking) // R21
    else $error("tracking did not end at eighth fall");

  a_dout_msb: assert property (s_fall_at(9) |=> // R19
    serial_out == $past(st_r.cap[`RES_W-1]))
    else $error("result msb not driven at ninth fall");

  a_res_len: assert property (s_fall_at(9) |=> // R4
    st_r.out_left == (res_8bit ? `RES8_LEFT : `RES12_LEFT))
    else $error("result length does not follow resolution");

  a_axis_sw: assert property (x_plus_terminal |-> // R6
    x_minus_terminal && !y_plus_terminal && !y_minus_terminal)
    else $error("x axis switch pairing broken");

  a_both_on: assert property (cs_s && !din_s && // R17
    st_r.cmd[1:0] == 2'h3 |=> touch_alert_n && adc_power_on)
    else $error("alert not forced high with both powers on");

  a_auto_off: assert property (cs_s && st_r.cmd[1:0] == 2'h0 // R13
    |=> !adc_power_on && !ref_power_on)
    else $error("converter or reference on in automatic mode");

  a_pen_window: assert property (st_r.cv != '0 |-> // R14 R16
    !pen_detect_en)
    else $error("pen detect active during conversion");

  a_na_open: assert property (st_r.fr_na && !cs_s |-> // R22
    !x_plus_terminal && !y_plus_terminal && !x_minus_terminal &&
    !y_minus_terminal)
    else $error("switch closed for unusable code");

endmodule : touch_ctrl

// ### verif/host_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// host side of the serial link
// ----------------------------------------
module host_model (
  // clock
  input wire logic ref_clk,
  // serial pins
  output logic chip_select_n,
  output logic serial_clock,
  output logic serial_in,
  input wire logic serial_out,
  // frame observation
  output logic mark,
  output logic rx_valid,
  output logic [11:0] rx_data
);
  initial
  begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
    mark = 1'b0;
    rx_valid = 1'b0;
    rx_data = 12'h000;
  end

  // half of the 160 ns link period
  task automatic half();
    repeat (8) @(posedge ref_clk);
  endtask : half

  // data line level while deselected; high means full power-down
  task automatic idle_din(input logic v);
    serial_in <= v;
  endtask : idle_din

  // link clock stands low outside frames; lead adds zero bits first
  task automatic frame(input logic [7:0] cmd, input int lead, input int nres);
    int k;
    logic [11:0] w;
    w = 12'h000;
    half();
    chip_select_n <= 1'b0;
    half();
    for (int i = 1; i <= lead + 24; i++)
    begin
      k = i - lead;
      serial_in <= (k >= 1 && k <= 8) ? cmd[8 - k] : 1'b0;
      repeat (6) @(posedge ref_clk);
      mark <= (k == 8);
      @(posedge ref_clk);
      mark <= 1'b0;
      @(posedge ref_clk);
      serial_clock <= 1'b1;
      if (k >= 10 && k < 10 + nres)
        w = {w[10:0], serial_out};
      half();
      serial_clock <= 1'b0;
    end
    half();
    chip_select_n <= 1'b1;
    rx_data <= w;
    rx_valid <= 1'b1;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
  endtask : frame
endmodule : host_model

// ### verif/test_touch_ctrl.sv
`timescale 1ns/1ps

`define CHK(n, e, a) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      n_errors++; \
      $display("[FAIL] %s expected %0h seen %0h", n, e, a); \
    end \
  end

module test_touch_ctrl;
  logic ref_clk, sys_rst, plate_contact;
  logic chip_select_n, serial_clock, serial_in, serial_out, serial_out_oe;
  logic [11:0] conv_result, rx_data, er;
  logic touch_alert_n, pen_detect_en, mark, rx_valid;
  logic x_plus_terminal, x_minus_terminal, y_plus_terminal, y_minus_terminal;
  logic ref_power_on, adc_power_on, tracking, differential_en, res_8bit;
  logic [2:0] channel_select;
  touch_pkg::ref_sel_t ref_select;
  logic [3:0] plates;
  logic [14:0] mid_seen, em;
  logic [11:0] q_res[$];
  logic [14:0] q_mid[$];
  int n_errors = 0;
  int comparisons = 0;

  assign plates = {x_plus_terminal, x_minus_terminal, y_plus_terminal,
    y_minus_terminal};
  assign mid_seen = {plates, ref_select, channel_select, differential_en,
    res_8bit, tracking, serial_out_oe, pen_detect_en, ref_power_on};

  touch_ctrl i_touch_ctrl (.ref_clk, .sys_rst, .chip_select_n, .serial_clock,
    .serial_in, .serial_out, .serial_out_oe, .plate_contact, .conv_result,
    .touch_alert_n, .pen_detect_en, .x_plus_terminal, .x_minus_terminal,
    .y_plus_terminal, .y_minus_terminal, .ref_power_on, .adc_power_on,
    .tracking, .channel_select, .differential_en, .ref_select, .res_8bit);

  host_model i_host_model (.ref_clk, .chip_select_n, .serial_clock,
    .serial_in, .serial_out, .mark, .rx_valid, .rx_data);

  // ----------------------------------------
  // expected levels just before the eighth rise
  // ----------------------------------------
  function automatic logic [14:0] mid_exp(logic [2:0] ch, logic ser,
    logic res, logic pd1);
    logic [3:0] sw;
    logic diff;
    touch_pkg::ref_sel_t rs;
    case (ch)
      3'h1: sw = 4'h3;
      3'h3, 3'h4: sw = 4'h6;
      3'h5: sw = 4'hc;
      default: sw = 4'h0;
    endcase
    case (ch)
      3'h1: rs = touch_pkg::REF_Y_PLATE;
      3'h3, 3'h4: rs = touch_pkg::REF_YP_XN;
      3'h5: rs = touch_pkg::REF_X_PLATE;
      default: rs = touch_pkg::REF_INTERNAL;
    endcase
    if (ser)
      rs = touch_pkg::REF_INTERNAL;
    diff = ~ser && (ch != 3'h6);
    return {sw, rs, ch, diff, res, 3'h6, pd1};
  endfunction : mid_exp

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    final_report();
  end

  // ----------------------------------------
  // watcher: oldest note against each result
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (rx_valid)
    begin
      er = q_res.pop_front();
      `CHK("result", er, rx_data)
    end
    if (mark)
    begin
      em = q_mid.pop_front();
      `CHK("mid frame", em, mid_seen)
    end
  end

  initial
  begin
    logic [11:0] v;
    sys_rst = 1'b1;
    plate_contact = 1'b0;
    conv_result = 12'h000;
    void'($urandom(32'h3580c240));
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    // both resolutions, with leading zero bits before the start flag
    for (int i = 0; i < 4; i++)
    begin
      v = 12'($urandom());
      conv_result <= v;
      q_res.push_back(i[0] ? {4'h0, v[11:4]} : v);
      q_mid.push_back(mid_exp(3'h5, 1'b1, i[0], 1'b0));
      i_host_model.frame({4'hd, i[0], 3'h4}, i, i[0] ? 8 : 12);
    end
    $display("test resolution done");
    // every channel code in both modes
    for (int m = 0; m < 16; m++)
    begin
      v = 12'($urandom());
      conv_result <= v;
      // unusable differential codes give a zero result
      q_res.push_back((!m[3] && m[2:0] inside {0, 2, 7}) ? 12'h000 : v);
      q_mid.push_back(mid_exp(m[2:0], m[3], 1'b0, 1'b0));
      i_host_model.frame({1'b1, m[2:0], 1'b0, m[3], 2'b00}, 0, 12);
    end
    $display("test channels done");
    // power modes, then the deselected levels they leave
    for (int p = 0; p < 4; p++)
    begin
      v = 12'($urandom());
      conv_result <= v;
      plate_contact <= 1'($urandom());
      q_res.push_back(v);
      q_mid.push_back(mid_exp(3'h5, 1'b1, 1'b0, p[1]));
      i_host_model.frame({4'hd, 2'b01, p[1:0]}, 0, 12);
      repeat (8) @(posedge ref_clk);
      `CHK("plates idle", 4'h1, plates)
      `CHK("ref power", p[1], ref_power_on)
      `CHK("adc power", p == 3, adc_power_on)
      `CHK("pen detect", p != 3, pen_detect_en)
      `CHK("alert", p == 3 ? 1'b1 : ~plate_contact, touch_alert_n)
    end
    $display("test power modes done");
    // full power-down from the both-on mode
    i_host_model.idle_din(1'b1);
    repeat (8) @(posedge ref_clk);
    `CHK("plates open", 4'h0, plates)
    `CHK("alert high", 1'b1, touch_alert_n)
    i_host_model.idle_din(1'b0);
    repeat (8) @(posedge ref_clk);
    `CHK("ref cleared", 1'b0, ref_power_on)
    `CHK("adc cleared", 1'b0, adc_power_on)
    `CHK("notes left", 0, q_res.size() + q_mid.size())
    $display("test power-down done");
    final_report();
  end
endmodule : test_touch_ctrl
